// File: sbl_edge.sv
// rising edge detector for a vector of same-domain sources
`timescale 1ns/1ps
module sbl_edge
    import sbl_pkg::*;
#(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // sources
    input  wire logic [W-1:0] level_in,
    output wire logic [W-1:0] rise_out
);
    logic [W-1:0] prev_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level_in;
        end
    end

    assign rise_out = level_in & ~prev_reg;

endmodule : sbl_edge

// File: sbl_irq_events.sv
// interrupt event register with its hardware sources
// Function
// - register byte received sets bit 26; byte readable in control bits 23-16
// - with master role set, over 125 us start to gap end sets bit 25
// - cycle overrun clears the master role bit 21 of link control
// - any halting error sets bit 24
// - while bit 24 set, normal events of failed contexts are blocked
// - received cycle start differing from timer fields sets bit 23
// - no cycle start between two new-cycle events sets bit 22
// - change of second counter bit six sets bit 21
// - toggle of cycle count low bit sets bit 20
// - transceiver status transfer interrupt sets bit 19
// - register access failing for missing link clock sets bit 18
// - transceiver entering bus reset sets bit 17
// - node id stream done sets bit 16; bus reset clears it
// - bit 15 set with bit 16, unaffected by bus reset
// - bits 14 to 10 read as zero
// - unacked lock response sets bit 9
// - host bus error on acked posted write sets bit 8
// - bit 7 is unlatched OR of receive context events and masks
// - bit 6 is unlatched OR of transmit context events and masks
// - packet stored in response or request buffer sets bit 5 or 4
// - receive descriptor completion sets bit 3 or 2
// - transmit command completion sets bit 1 or 0
// - bits set on source rising edge or writing one at 80h
// - bits clear only by writing one at 84h, except bit 16, which bus reset also clears
// - event read returns events AND mask
// - interrupt needs global enable and an enabled pending event
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module sbl_irq_events
    import sbl_pkg::*;
#(
    parameter int NRX = 4,
    parameter int NTX = 4
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // transceiver side
    input  wire logic              xcvr_byte_valid,
    input  wire logic [7:0]        xcvr_byte,
    input  wire logic              xcvr_irq,
    input  wire logic              xcvr_acc_fail,
    input  wire logic              xcvr_bus_reset,
    // cycle timing
    input  wire logic              cyc_start_tx,
    input  wire logic              cyc_start_rx,
    input  wire logic [6:0]        rx_seconds,
    input  wire logic [12:0]       rx_ticks,
    input  wire logic              subgap_end,
    input  wire logic              arb_reset_gap,
    input  wire logic [31:0]       cyc_timer,
    // link and dma conditions
    input  wire logic              fatal_err,
    input  wire logic [3:0]        fatal_ctx,
    input  wire logic              node_id_done,
    input  wire logic              lock_unacked,
    input  wire logic              posted_fault,
    input  wire logic              resp_stored,
    input  wire logic              req_stored,
    input  wire logic              resp_rx_done,
    input  wire logic              req_rx_done,
    input  wire logic              resp_tx_done,
    input  wire logic              req_tx_done,
    input  wire logic [NRX-1:0]    rx_ctx_event,
    input  wire logic [NRX-1:0]    rx_ctx_mask,
    input  wire logic [NTX-1:0]    tx_ctx_event,
    input  wire logic [NTX-1:0]    tx_ctx_mask,
    // outputs
    output logic                   cycle_master_role,
    output logic                   irq
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [31:0] evt_reg, evt_next;
    logic [31:0] msk_reg, msk_next;
    logic [31:0] link_reg, link_next;
    logic [7:0]  xbyte_reg;
    logic [31:0] rdata_reg;
    logic        irq_reg;
    logic        seen_start_reg;
    logic        gap_armed_reg;
    logic        msec_reg;
    logic        tlsb_reg;
    logic [31:0] raw_src;
    logic [31:0] src_rise;
    logic        overrun;

    // ************************************************************
    // decode
    // ************************************************************
    wire wr_evt_set  = reg_wr && reg_addr == EVT_SET_OFS;
    wire wr_evt_clr  = reg_wr && reg_addr == EVT_CLR_OFS;
    wire wr_msk_set  = reg_wr && reg_addr == MSK_SET_OFS;
    wire wr_msk_clr  = reg_wr && reg_addr == MSK_CLR_OFS;
    wire wr_link     = reg_wr && reg_addr == LINK_CTL_OFS;
    wire new_cycle   = cyc_timer[TICK_LSB] != tlsb_reg;
    wire sec_roll    = cyc_timer[SEC_LSB+SEC_ROLL_BIT] != msec_reg;
    wire any_start   = cyc_start_tx || cyc_start_rx;
    wire mismatch    = cyc_start_rx &&
        (rx_seconds != cyc_timer[31:SEC_LSB] ||
         rx_ticks != cyc_timer[SEC_LSB-1:TICK_LSB]);
    // lost cycle: no start since last tick, or predicted early
    wire missed      = (new_cycle && !seen_start_reg) ||
                       (gap_armed_reg && subgap_end && !any_start) ||
                       (arb_reset_gap && !seen_start_reg);
    // contexts 0..3: resp tx, req tx, resp rx, req rx
    wire blk_rtx     = evt_reg[BIT_FATAL] && fatal_ctx[0];
    wire blk_qtx     = evt_reg[BIT_FATAL] && fatal_ctx[1];
    wire blk_rrx     = evt_reg[BIT_FATAL] && fatal_ctx[2];
    wire blk_qrx     = evt_reg[BIT_FATAL] && fatal_ctx[3];

    // ************************************************************
    // hardware sources
    // ************************************************************
    always_comb begin
        raw_src                  = '0;
        raw_src[BIT_REG_RCVD]    = xcvr_byte_valid;
        raw_src[BIT_OVERRUN]     = overrun;
        raw_src[BIT_FATAL]       = fatal_err;
        raw_src[BIT_MISMATCH]    = mismatch;
        raw_src[BIT_MISSED]      = missed;
        raw_src[BIT_ROLLOVER]    = sec_roll;
        raw_src[BIT_NEW_CYCLE]   = new_cycle;
        raw_src[BIT_XCVR_IRQ]    = xcvr_irq;
        raw_src[BIT_ACC_TIMEOUT] = xcvr_acc_fail;
        raw_src[BIT_BUS_RESET]   = xcvr_bus_reset;
        raw_src[BIT_ID_DONE]     = node_id_done;
        raw_src[BIT_ID_DONE2]    = node_id_done;
        raw_src[9]               = lock_unacked;
        raw_src[8]               = posted_fault;
        raw_src[5]               = resp_stored && !blk_rrx;
        raw_src[4]               = req_stored && !blk_qrx;
        raw_src[3]               = resp_rx_done && !blk_rrx;
        raw_src[2]               = req_rx_done && !blk_qrx;
        raw_src[1]               = resp_tx_done && !blk_rtx;
        raw_src[0]               = req_tx_done && !blk_qtx;
    end

    sbl_edge #(
        .W (32)
    ) u_edge (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .level_in (raw_src),
        .rise_out (src_rise)
    );

    sbl_overrun #(
        .LIMIT (CYCLE_MAX_CYC)
    ) u_overrun (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .armed    (link_reg[BIT_MASTER_ROLE]),
        .start_tx (cyc_start_tx),
        .gap_end  (subgap_end),
        .overrun  (overrun)
    );

    // ************************************************************
    // event and mask update
    // ************************************************************
    wire [31:0] hw_set   = src_rise & EVT_LATCH_MASK;
    wire [31:0] sw_set   = wr_evt_set ? reg_wdata : 32'h0000_0000;
    wire [31:0] sw_clr   = wr_evt_clr ? reg_wdata : 32'h0000_0000;
    wire [31:0] id_clr   = hw_set[BIT_BUS_RESET] ?
                           32'h0001_0000 : 32'h0000_0000;
    wire [31:0] live_evt = evt_reg & EVT_LATCH_MASK;
    wire        rx_sum   = |(rx_ctx_event & rx_ctx_mask);
    wire        tx_sum   = |(tx_ctx_event & tx_ctx_mask);
    wire [31:0] evt_view = live_evt |
                           ({31'h0, rx_sum} << BIT_TIMED_RX) |
                           ({31'h0, tx_sum} << BIT_TIMED_TX);

    always_comb begin
        // set wins over clear; bit 16 drops when bus reset rises
        evt_next = ((evt_reg & ~sw_clr & ~id_clr) | sw_set | hw_set)
                   & EVT_LATCH_MASK;
        msk_next = wr_msk_set ? (msk_reg | reg_wdata) :
                   wr_msk_clr ? (msk_reg & ~reg_wdata) : msk_reg;
        link_next = wr_link ? reg_wdata : link_reg;
        if (overrun) begin
            link_next[BIT_MASTER_ROLE] = 1'b0;
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    wire rd_evt = reg_addr == EVT_SET_OFS || reg_addr == EVT_CLR_OFS;
    wire rd_msk = reg_addr == MSK_SET_OFS || reg_addr == MSK_CLR_OFS;
    wire [31:0] rd_val =
        rd_evt ? (evt_view & msk_reg) :
        rd_msk ? msk_reg :
        reg_addr == LINK_CTL_OFS  ? link_reg :
        reg_addr == XCVR_CTL_OFS  ? {8'h00, xbyte_reg, 16'h0000} :
        reg_addr == CYC_TIMER_OFS ? cyc_timer : 32'h0000_0000;

    wire irq_next = msk_reg[BIT_GLOBAL_EN] &&
                    |(evt_view & msk_reg & ~32'h8000_0000);

    // ************************************************************
    // state
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt_reg  <= EVT_RESET;
            msk_reg  <= MSK_RESET;
            link_reg <= LINK_RESET;
        end else begin
            evt_reg  <= evt_next;
            msk_reg  <= msk_next;
            link_reg <= link_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xbyte_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            irq_reg   <= 1'b0;
        end else begin
            if (xcvr_byte_valid) begin
                xbyte_reg <= xcvr_byte;
            end
            rdata_reg <= reg_rd ? rd_val : 32'h0000_0000;
            irq_reg   <= irq_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen_start_reg <= 1'b1;
            gap_armed_reg  <= 1'b0;
            msec_reg       <= 1'b0;
            tlsb_reg       <= 1'b0;
        end else begin
            msec_reg <= cyc_timer[SEC_LSB+SEC_ROLL_BIT];
            tlsb_reg <= cyc_timer[TICK_LSB];
            if (new_cycle) begin
                seen_start_reg <= any_start;
                gap_armed_reg  <= 1'b1;
            end else begin
                if (any_start) begin
                    seen_start_reg <= 1'b1;
                end
                if (subgap_end || any_start) begin
                    gap_armed_reg <= 1'b0;
                end
            end
        end
    end

    assign reg_rdata         = rdata_reg;
    assign irq               = irq_reg;
    assign cycle_master_role = link_reg[BIT_MASTER_ROLE];

    // ************************************************************
    // checks
    // ************************************************************
    property p_set_wins;
        @(posedge clk_sys) disable iff (!rst_n)
        |(hw_set & sw_clr) |=> (evt_reg & $past(hw_set)) == $past(hw_set);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("hardware set lost to clear");

    property p_clear_only;
        @(posedge clk_sys) disable iff (!rst_n)
        (evt_reg[0] && !(wr_evt_clr && reg_wdata[0])) |=> evt_reg[0];
    endproperty
    a_clear_only: assert property (p_clear_only)
        else $error("event bit dropped without clear");

    property p_sw_set;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_evt_set && reg_wdata[9]) |=> evt_reg[9];
    endproperty
    a_sw_set: assert property (p_sw_set)
        else $error("software set ignored");

    property p_read_and;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && rd_evt) |=> reg_rdata == ($past(evt_view) & $past(msk_reg));
    endproperty
    a_read_and: assert property (p_read_and)
        else $error("event read not masked");

    property p_rsvd;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && rd_evt) |=> reg_rdata[14:10] == 5'h00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits nonzero");

    property p_irq_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        !msk_reg[BIT_GLOBAL_EN] |=> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq without global enable");

    property p_role_drop;
        @(posedge clk_sys) disable iff (!rst_n)
        overrun |=> !cycle_master_role && evt_reg[BIT_OVERRUN];
    endproperty
    a_role_drop: assert property (p_role_drop)
        else $error("master role kept after overrun");

    property p_fatal_block;
        @(posedge clk_sys) disable iff (!rst_n)
        (blk_rtx && !evt_reg[1] && !wr_evt_set) |=> !evt_reg[1];
    endproperty
    a_fatal_block: assert property (p_fatal_block)
        else $error("blocked context event was set");

    property p_new_cycle;
        @(posedge clk_sys) disable iff (!rst_n)
        (cyc_timer[TICK_LSB] != tlsb_reg) |=> evt_reg[BIT_NEW_CYCLE];
    endproperty
    a_new_cycle: assert property (p_new_cycle)
        else $error("cycle tick toggle not latched");

    sequence s_bus_reset_rise;
        hw_set[BIT_BUS_RESET] && !hw_set[BIT_ID_DONE] && !reg_wr;
    endsequence
    property p_id_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        s_bus_reset_rise |=> evt_reg[BIT_BUS_RESET] && !evt_reg[BIT_ID_DONE]
            && evt_reg[BIT_ID_DONE2] == $past(evt_reg[BIT_ID_DONE2]);
    endproperty
    a_id_clear: assert property (p_id_clear)
        else $error("node id done kept across bus reset");

endmodule : sbl_irq_events

// File: sbl_irq_events_bench.sv
// self-checking bench for the interrupt event block
`timescale 1ns/1ps
module sbl_irq_events_bench
    import sbl_pkg::*;
;
    // ************************************************************
    // stimulus and observation signals
    // ************************************************************
    logic        clk_sys, rst_n, reg_wr, reg_rd, rd_pend;
    logic        cycle_master_role, irq;
    logic [7:0]  reg_addr, xcvr_byte;
    logic [31:0] reg_wdata, reg_rdata, cyc_timer, src, v, m;
    logic [6:0]  rx_seconds;
    logic [12:0] rx_ticks;
    logic [3:0]  fatal_ctx, rx_ctx_event, rx_ctx_mask;
    logic [3:0]  tx_ctx_event, tx_ctx_mask;
    logic [63:0] note;
    logic [63:0] exp_q[$];
    logic [31:0] seed = 32'h5617;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          n;
    int          hw_bits[12] = '{26, 19, 18, 17, 9, 8, 5, 4, 3, 2, 1, 0};

    // src bits follow event positions; 27..30 carry the cycle strobes
    sbl_irq_events i_dut (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .xcvr_byte_valid(src[26]), .xcvr_byte,
        .xcvr_irq(src[19]), .xcvr_acc_fail(src[18]),
        .xcvr_bus_reset(src[17]), .cyc_start_tx(src[27]),
        .cyc_start_rx(src[28]), .rx_seconds, .rx_ticks,
        .subgap_end(src[29]), .arb_reset_gap(src[30]), .cyc_timer,
        .fatal_err(src[24]), .fatal_ctx, .node_id_done(src[16]),
        .lock_unacked(src[9]), .posted_fault(src[8]),
        .resp_stored(src[5]), .req_stored(src[4]),
        .resp_rx_done(src[3]), .req_rx_done(src[2]),
        .resp_tx_done(src[1]), .req_tx_done(src[0]),
        .rx_ctx_event, .rx_ctx_mask, .tx_ctx_event, .tx_ctx_mask,
        .cycle_master_role, .irq
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // the expected word is noted with the bits that matter
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] k = 32'hffff_ffff);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back({k, e});
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
    endtask : rd

    task automatic pulse(input int b);
        @(posedge clk_sys);
        src[b] <= 1'b1;
        @(posedge clk_sys);
        src[b] <= 1'b0;
    endtask : pulse

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys) rd_pend <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_pend === 1'b1) begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 64'h0;
            chk(reg_rdata & note[63:32], note[31:0] & note[63:32]);
        end
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, src} = '0;
        {xcvr_byte, rx_seconds, rx_ticks, cyc_timer, fatal_ctx} = '0;
        {rx_ctx_event, rx_ctx_mask, tx_ctx_event, tx_ctx_mask} = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(EVT_SET_OFS, EVT_RESET);
        rd(MSK_SET_OFS, MSK_RESET);
        rd(LINK_CTL_OFS, LINK_RESET);
        rd(8'h40, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            m = rnd() | {i[0], 31'h0};
            v = rnd();
            wr(MSK_CLR_OFS, 32'hffff_ffff);
            wr(MSK_SET_OFS, m);
            rd(MSK_CLR_OFS, m);
            wr(EVT_SET_OFS, v);
            rd(EVT_SET_OFS, v & m & EVT_LATCH_MASK);
            rd(EVT_CLR_OFS, v & m & EVT_LATCH_MASK);
            #1 chk(irq, m[31] && |(v & m & EVT_LATCH_MASK));
            wr(EVT_CLR_OFS, v);
            rd(EVT_SET_OFS, 32'h0);
            settle;
            chk(irq, 0);
        end
        wr(MSK_SET_OFS, 32'hffff_ffff);
        $display("test software set clear done");
        foreach (hw_bits[k]) begin
            v = rnd();
            xcvr_byte <= v[7:0];
            pulse(hw_bits[k]);
            rd(EVT_SET_OFS, 32'h1 << hw_bits[k]);
            #1 chk(irq, 1);
            if (hw_bits[k] == 26) begin
                rd(XCVR_CTL_OFS, {8'h0, v[7:0], 16'h0}, 32'h00ff_0000);
            end
            wr(EVT_CLR_OFS, 32'h1 << hw_bits[k]);
            settle;
            chk(irq, 0);
        end
        pulse(16);
        rd(EVT_SET_OFS, 32'h0001_8000);
        pulse(17);
        rd(EVT_SET_OFS, 32'h0002_8000);
        wr(EVT_CLR_OFS, 32'h0002_8000);
        fork
            wr(EVT_CLR_OFS, 32'h0000_0200);
            pulse(9);
        join
        rd(EVT_SET_OFS, 32'h0000_0200);
        wr(MSK_CLR_OFS, 32'h8000_0000);
        settle;
        chk(irq, 0);
        wr(MSK_SET_OFS, 32'h8000_0000);
        wr(EVT_CLR_OFS, 32'h0000_0200);
        $display("test hardware sources done");
        fatal_ctx <= 4'h1;
        pulse(24);
        pulse(1);
        pulse(0);
        rd(EVT_SET_OFS, 32'h0100_0001);
        wr(EVT_CLR_OFS, 32'h0100_0001);
        pulse(1);
        rd(EVT_SET_OFS, 32'h0000_0002);
        wr(EVT_CLR_OFS, 32'h0000_0002);
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            {tx_ctx_mask, tx_ctx_event, rx_ctx_mask, rx_ctx_event} <= v[15:0];
            settle;
            rd(EVT_SET_OFS, {24'h0, |(v[3:0] & v[7:4]),
                |(v[11:8] & v[15:12]), 6'h0}, 32'h0000_00c0);
        end
        {rx_ctx_event, tx_ctx_event} <= 8'h00;
        $display("test fatal and summaries done");
        wr(LINK_CTL_OFS, 32'h0020_0000);
        rd(LINK_CTL_OFS, 32'h0020_0000);
        pulse(27);
        repeat (4000) @(posedge clk_sys);
        pulse(29);
        repeat (2000) @(posedge clk_sys);
        #1 chk(cycle_master_role, 1);
        rd(EVT_SET_OFS, 32'h0);
        pulse(27);
        n = 0;
        while (cycle_master_role === 1'b1 && n < 6000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(n >= 4998 && n <= 5004, 1);
        rd(EVT_SET_OFS, 32'h0200_0000);
        rd(LINK_CTL_OFS, 32'h0);
        wr(EVT_CLR_OFS, 32'h0200_0000);
        $display("test overrun done");
        rx_seconds <= cyc_timer[31:25];
        rx_ticks   <= cyc_timer[24:12];
        pulse(28);
        rd(EVT_SET_OFS, 32'h0);
        cyc_timer <= cyc_timer ^ 32'h0000_1000;
        settle;
        rd(EVT_SET_OFS, 32'h0010_0000);
        pulse(30);
        rd(EVT_SET_OFS, 32'h0050_0000);
        wr(EVT_CLR_OFS, 32'h0050_0000);
        cyc_timer <= cyc_timer ^ 32'h0000_1000;
        settle;
        rd(EVT_SET_OFS, 32'h0050_0000);
        wr(EVT_CLR_OFS, 32'h0050_0000);
        rx_ticks <= ~cyc_timer[24:12];
        pulse(28);
        rd(EVT_SET_OFS, 32'h0080_0000);
        cyc_timer <= cyc_timer ^ 32'h8000_0000;
        settle;
        rd(EVT_SET_OFS, 32'h00a0_0000);
        cyc_timer <= cyc_timer ^ 32'h0000_1000;
        settle;
        pulse(29);
        rd(EVT_SET_OFS, 32'h00f0_0000);
        $display("test cycle timing done");
        repeat (4) @(posedge clk_sys);
        chk(exp_q.size(), 0);
        finish_test();
    end
endmodule : sbl_irq_events_bench

// File: sbl_overrun.sv
// watchdog timing a cycle start against the subaction gap end
`timescale 1ns/1ps
module sbl_overrun
    import sbl_pkg::*;
#(
    parameter int LIMIT = CYCLE_MAX_CYC
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // timing events
    input  wire logic armed,
    input  wire logic start_tx,
    input  wire logic gap_end,
    output wire logic overrun
);
    logic [CNT_W-1:0] cnt_reg;
    logic             run_reg;
    logic             over_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            run_reg  <= 1'b0;
            over_reg <= 1'b0;
        end else begin
            over_reg <= 1'b0;
            if (start_tx && armed) begin
                cnt_reg <= '0;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (gap_end || !armed) begin
                    run_reg <= 1'b0;
                end else if (cnt_reg == CNT_W'(LIMIT)) begin
                    // just past the limit
                    over_reg <= 1'b1;
                    run_reg  <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end

    assign overrun = over_reg;

endmodule : sbl_overrun

// File: sbl_pkg.sv
// shared constants for the serial bus link interrupt event block
package sbl_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] EVT_SET_OFS    = 8'h80;
    localparam logic [7:0] EVT_CLR_OFS    = 8'h84;
    localparam logic [7:0] MSK_SET_OFS    = 8'h88;
    localparam logic [7:0] MSK_CLR_OFS    = 8'h8c;
    localparam logic [7:0] LINK_CTL_OFS   = 8'he0;
    localparam logic [7:0] XCVR_CTL_OFS   = 8'hec;
    localparam logic [7:0] CYC_TIMER_OFS  = 8'hf0;

    // ************************************************************
    // event, control and timer bit positions
    // ************************************************************
    localparam int BIT_REG_RCVD    = 26;
    localparam int BIT_OVERRUN     = 25;
    localparam int BIT_FATAL       = 24;
    localparam int BIT_MISMATCH    = 23;
    localparam int BIT_MISSED      = 22;
    localparam int BIT_ROLLOVER    = 21;
    localparam int BIT_NEW_CYCLE   = 20;
    localparam int BIT_XCVR_IRQ    = 19;
    localparam int BIT_ACC_TIMEOUT = 18;
    localparam int BIT_BUS_RESET   = 17;
    localparam int BIT_ID_DONE     = 16;
    localparam int BIT_ID_DONE2    = 15;
    localparam int BIT_TIMED_RX    = 7;
    localparam int BIT_TIMED_TX    = 6;
    localparam int BIT_MASTER_ROLE = 21;
    localparam int BIT_GLOBAL_EN   = 31;
    localparam int XCVR_DATA_LSB   = 16;
    localparam int SEC_LSB         = 25;
    localparam int TICK_LSB        = 12;
    localparam int SEC_ROLL_BIT    = 6;

    // latched bits: 30..15 less unsupported, 9..0 less 7,6
    localparam logic [31:0] EVT_LATCH_MASK = 32'h07ff_833f;
    localparam logic [31:0] EVT_RESET      = 32'h0000_0000;
    localparam logic [31:0] MSK_RESET      = 32'h0000_0000;
    localparam logic [31:0] LINK_RESET     = 32'h0000_0000;

    // ************************************************************
    // cycle timing
    // ************************************************************
    localparam int CLK_MHZ       = 40;
    localparam int CYCLE_MAX_US  = 125;
    localparam int CYCLE_MAX_CYC = CYCLE_MAX_US * CLK_MHZ;
    localparam int CNT_W         = 13;

endpackage : sbl_pkg
